// ---- ltfs_seq.sv ----
// The register offsets and the strobed register port are this design's own decisions.
module ltfs_seq #(
	parameter logic [31:0] PAUSE_CYCLES = 32'h0000_4e20
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic external_line_sync_input,
	input wire logic frame_trig_in,
	input wire logic tsmod_event,
	output ltfs_pkg::ltfs_line_t line_out
);

	////////////////////////////////////////////////////////////////////
	// State
	ltfs_pkg::ltfs_regs_t r_r; // Registered state
	ltfs_pkg::ltfs_regs_t r_nxt; // Next state

	// Frame trigger type gate: whether a line may be taken now
	logic line_trig;
	logic grab; // Grab in progress
	logic [31:0] min_period; // Effective period
	ltfs_pkg::ltfs_type_t ttype;
	ltfs_pkg::ltfs_lsrc_t lsrc;
	ltfs_pkg::ltfs_edge_t edge_sel;
	ltfs_pkg::ltfs_edge_t fedge;
	logic ext_edge; // Qualified edge of filtered input
	logic frm_edge; // Frame trigger edge
	logic cmd_trig; // Host command strobe
	logic can_fire; // Line period elapsed
	logic fire; // A line is taken this cycle
	logic want; // A trigger is requested
	// Timer origin asks every cycle; it must never pend or flag overrun
	logic free_tmr;

	// Edge test shared by line and frame inputs
	function automatic logic edge_hit(input logic now, input logic was,
		input ltfs_pkg::ltfs_edge_t sel);
		case (sel)
			ltfs_pkg::EDGE_RISE: edge_hit = now & ~was;
			ltfs_pkg::EDGE_FALL: edge_hit = ~now & was;
			ltfs_pkg::EDGE_ANY: edge_hit = now ^ was;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		r_nxt = r_r;
		grab = r_r.ctrl[ltfs_pkg::CTRL_GRAB];
		lsrc = ltfs_pkg::ltfs_lsrc_t'(r_r.ctrl[ltfs_pkg::CTRL_LSRC_LO +: 2]);
		ttype = ltfs_pkg::ltfs_type_t'(r_r.ctrl[ltfs_pkg::CTRL_TYPE_LO +: 3]);
		edge_sel = ltfs_pkg::ltfs_edge_t'(r_r.ctrl[ltfs_pkg::CTRL_EDGE_LO +: 2]);
		fedge = ltfs_pkg::ltfs_edge_t'(r_r.ctrl[ltfs_pkg::CTRL_FSRC_LO +: 2]);
		// Exposure bounds the period so lines never overlap
		min_period = (r_r.line_period > r_r.exposure) ? r_r.line_period
			: r_r.exposure;
		cmd_trig = reg_wr && (reg_addr == ltfs_pkg::ADDR_CMD);
		r_nxt.out = '0;
		r_nxt.out.line_index = r_r.out.line_index;
		r_nxt.out.frame_index = r_r.out.frame_index;

		// Debounce: input must hold a new level for one cycle more than the set count
		r_nxt.ext_d = r_r.ext_filt;
		if (external_line_sync_input == r_r.ext_filt) begin
			r_nxt.db_cnt = '0;
		end else if (r_r.db_cnt >= r_r.debounce) begin
			r_nxt.ext_filt = external_line_sync_input;
			r_nxt.db_cnt = '0;
		end else begin
			r_nxt.db_cnt = r_r.db_cnt + 16'h0001;
		end
		ext_edge = edge_hit(r_r.ext_filt, r_r.ext_d, edge_sel);
		r_nxt.frm_lvl_d = frame_trig_in;
		frm_edge = edge_hit(frame_trig_in, r_r.frm_lvl_d, fedge);

		// Line trigger origin
		r_nxt.tmr = (r_r.tmr == 32'h0) ? 32'h0 : r_r.tmr - 32'h1;
		can_fire = (r_r.tmr == 32'h0);
		if (!r_r.ctrl[ltfs_pkg::CTRL_TRIG_ON]) begin
			want = 1'b1;
		end else begin
			case (lsrc)
				ltfs_pkg::LSRC_TIMER: want = 1'b1;
				ltfs_pkg::LSRC_EXT: want = ext_edge;
				ltfs_pkg::LSRC_CMD: want = cmd_trig;
				ltfs_pkg::LSRC_TSMOD: want = tsmod_event;
				default: want = 1'b0;
			endcase
		end

		// Whether this trigger type is currently capturing
		case (ttype)
			ltfs_pkg::TYPE_LINE: line_trig = 1'b1;
			ltfs_pkg::TYPE_ACTIVE: line_trig = r_r.armed & frame_trig_in;
			default: line_trig = r_r.armed;
		endcase

		// Pending trigger: one held, the rest dropped
		fire = 1'b0;
		free_tmr = !r_r.ctrl[ltfs_pkg::CTRL_TRIG_ON]
			|| (lsrc == ltfs_pkg::LSRC_TIMER);
		if (!grab) begin
			r_nxt.pend = 1'b0;
		end else if (want && !can_fire && !free_tmr) begin
			if (r_r.pend) r_nxt.overrun = 1'b1;
			r_nxt.pend = 1'b1;
		end else if (can_fire && (want || r_r.pend) && line_trig
			&& r_r.st == ltfs_pkg::ST_RUN) begin
			fire = 1'b1;
			r_nxt.pend = 1'b0;
			r_nxt.tmr = min_period - 32'h1;
		end

		// Arm on frame triggers
		if (grab) begin
			case (ttype)
				ltfs_pkg::TYPE_SINGLE: begin
					if (frm_edge && !r_r.armed) begin
						r_nxt.armed = 1'b1;
						r_nxt.frames_left = 16'h0001;
					end
				end
				ltfs_pkg::TYPE_MULTI: begin
					if (frm_edge && !r_r.armed) begin
						r_nxt.armed = 1'b1;
						r_nxt.frames_left = r_r.frames;
					end
				end
				ltfs_pkg::TYPE_ACTIVE, ltfs_pkg::TYPE_BURST: begin
					if (frame_trig_in && !r_r.armed && r_r.line_cnt == 16'h0) begin
						r_nxt.armed = 1'b1;
						r_nxt.frames_left = 16'h0001;
					end
				end
				default: r_nxt.armed = 1'b0;
			endcase
		end

		// Gap counter for per-line pauses
		r_nxt.gap = fire ? 32'h0 : ((r_r.gap == PAUSE_CYCLES) ? r_r.gap
			: r_r.gap + 32'h1);

		// Sequencer
		case (r_r.st)
			ltfs_pkg::ST_IDLE: begin
				if (grab) begin
					r_nxt.st = ltfs_pkg::ST_RUN;
					r_nxt.line_cnt = '0;
					r_nxt.frame_cnt = '0;
					r_nxt.armed = 1'b0;
					r_nxt.overrun = 1'b0;
				end
			end
			ltfs_pkg::ST_RUN: begin
				if (!grab) begin
					r_nxt.st = ltfs_pkg::ST_IDLE;
					r_nxt.armed = 1'b0;
				end else if (fire) begin
					r_nxt.out.line_strobe = 1'b1;
					r_nxt.out.frame_start = (r_r.line_cnt == 16'h0);
					r_nxt.out.line_index = r_r.line_cnt;
					r_nxt.out.frame_index = r_r.frame_cnt;
					if (r_r.line_cnt + 16'h1 >= r_r.height) begin
						r_nxt.out.frame_end = 1'b1;
						r_nxt.line_cnt = '0;
						r_nxt.frame_cnt = r_r.frame_cnt + 16'h1;
						if (ttype == ltfs_pkg::TYPE_BURST) begin
							// Keep going while level holds; finish otherwise
							r_nxt.armed = frame_trig_in;
						end else if (ttype != ltfs_pkg::TYPE_LINE) begin
							r_nxt.frames_left = r_r.frames_left - 16'h1;
							r_nxt.armed = (r_r.frames_left > 16'h1);
						end
					end else begin
						r_nxt.line_cnt = r_r.line_cnt + 16'h1;
					end
				end else if (ttype == ltfs_pkg::TYPE_ACTIVE && r_r.armed
					&& !frame_trig_in && r_r.line_cnt != 16'h0) begin
					// Level dropped: pad the rest of the frame out to full height
					r_nxt.armed = 1'b0;
					r_nxt.st = ltfs_pkg::ST_FILL;
				end else if (ttype == ltfs_pkg::TYPE_LINE && r_r.line_cnt != 16'h0
					&& r_r.gap == PAUSE_CYCLES) begin
					// Triggers paused mid-frame: pad then restart
					r_nxt.st = ltfs_pkg::ST_FILL;
				end
			end
			ltfs_pkg::ST_FILL: begin
				// One zero line per cycle to complete the buffer
				r_nxt.out.line_strobe = 1'b1;
				r_nxt.out.zero_fill = 1'b1;
				r_nxt.out.line_index = r_r.line_cnt;
				r_nxt.out.frame_index = r_r.frame_cnt;
				if (r_r.line_cnt + 16'h1 >= r_r.height) begin
					r_nxt.out.frame_end = 1'b1;
					r_nxt.line_cnt = '0;
					r_nxt.frame_cnt = r_r.frame_cnt + 16'h1;
					r_nxt.st = ltfs_pkg::ST_RUN;
				end else begin
					r_nxt.line_cnt = r_r.line_cnt + 16'h1;
				end
			end
			default: r_nxt.st = ltfs_pkg::ST_IDLE;
		endcase

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				ltfs_pkg::ADDR_CTRL: r_nxt.ctrl = reg_wdata;
				ltfs_pkg::ADDR_LINE_PERIOD: r_nxt.line_period = reg_wdata;
				ltfs_pkg::ADDR_EXPOSURE: r_nxt.exposure = reg_wdata;
				ltfs_pkg::ADDR_HEIGHT: r_nxt.height = (reg_wdata[15:0] == 16'h0)
					? 16'h0001 : reg_wdata[15:0];
				ltfs_pkg::ADDR_FRAMES: r_nxt.frames = reg_wdata[15:0];
				ltfs_pkg::ADDR_DEBOUNCE: r_nxt.debounce = reg_wdata[15:0];
				default: ;
			endcase
		end

		// Register reads, data valid the next cycle
		r_nxt.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ltfs_pkg::ADDR_CTRL: r_nxt.rdata = r_r.ctrl;
				ltfs_pkg::ADDR_LINE_PERIOD: r_nxt.rdata = r_r.line_period;
				ltfs_pkg::ADDR_EXPOSURE: r_nxt.rdata = r_r.exposure;
				ltfs_pkg::ADDR_HEIGHT: r_nxt.rdata = {16'h0, r_r.height};
				ltfs_pkg::ADDR_FRAMES: r_nxt.rdata = {16'h0, r_r.frames};
				ltfs_pkg::ADDR_DEBOUNCE: r_nxt.rdata = {16'h0, r_r.debounce};
				ltfs_pkg::ADDR_STATUS: r_nxt.rdata = {r_r.frame_cnt,
					r_r.line_cnt[12:0], r_r.overrun, r_r.armed, grab};
				// Frame period in cycles; rate is its reciprocal
				ltfs_pkg::ADDR_FRAME_PERIOD: r_nxt.rdata =
					32'(min_period * r_r.height);
				default: r_nxt.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_r <= '0;
			r_r.st <= ltfs_pkg::ST_IDLE;
			r_r.line_period <= ltfs_pkg::RST_LINE_PERIOD;
			r_r.exposure <= ltfs_pkg::RST_EXPOSURE;
			r_r.height <= ltfs_pkg::RST_HEIGHT;
			r_r.frames <= ltfs_pkg::RST_FRAMES;
			r_r.debounce <= ltfs_pkg::RST_DEBOUNCE;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign reg_rdata = r_r.rdata;
	assign line_out = r_r.out;

endmodule : ltfs_seq

// ---- ltfs_pkg.sv ----
package ltfs_pkg;

	// Register offsets (word index equals byte address / 4)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LINE_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
	localparam logic [7:0] ADDR_HEIGHT = 8'h0c;
	localparam logic [7:0] ADDR_FRAMES = 8'h10;
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_FRAME_PERIOD = 8'h1c;
	localparam logic [7:0] ADDR_CMD = 8'h20;

	// Control field positions
	localparam int CTRL_GRAB = 0;
	localparam int CTRL_TRIG_ON = 1;
	localparam int CTRL_LSRC_LO = 2;
	localparam int CTRL_TYPE_LO = 4;
	localparam int CTRL_EDGE_LO = 7;
	localparam int CTRL_FSRC_LO = 9;

	// Reset values
	localparam logic [31:0] RST_LINE_PERIOD = 32'h0000_03e8;
	localparam logic [31:0] RST_EXPOSURE = 32'h0000_0064;
	localparam logic [15:0] RST_HEIGHT = 16'h000a;
	localparam logic [15:0] RST_FRAMES = 16'h0001;
	localparam logic [15:0] RST_DEBOUNCE = 16'h0004;

	// Line trigger origin
	typedef enum logic [1:0] {
		LSRC_TIMER = 2'h0,
		LSRC_EXT = 2'h1,
		LSRC_CMD = 2'h2,
		LSRC_TSMOD = 2'h3
	} ltfs_lsrc_t;

	// Frame-level trigger type
	typedef enum logic [2:0] {
		TYPE_LINE = 3'h0,
		TYPE_SINGLE = 3'h1,
		TYPE_MULTI = 3'h2,
		TYPE_ACTIVE = 3'h3,
		TYPE_BURST = 3'h4
	} ltfs_type_t;

	// Edge selection
	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_ANY = 2'h2
	} ltfs_edge_t;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_FILL = 3'b100
	} ltfs_state_t;

	// Line output to the readout path
	typedef struct packed {
		logic line_strobe;
		logic frame_start;
		logic frame_end;
		logic zero_fill;
		logic [15:0] line_index;
		logic [15:0] frame_index;
	} ltfs_line_t;

	// Whole state of the sequencer
	typedef struct packed {
		ltfs_state_t st;
		logic [31:0] ctrl;
		logic [31:0] line_period;
		logic [31:0] exposure;
		logic [15:0] height;
		logic [15:0] frames;
		logic [15:0] debounce;
		logic [31:0] tmr;
		logic [31:0] gap;
		logic [15:0] db_cnt;
		logic ext_filt;
		logic frm_lvl_d;
		logic ext_d;
		logic pend;
		logic armed;
		logic [15:0] line_cnt;
		logic [15:0] frame_cnt;
		logic [15:0] frames_left;
		logic overrun;
		logic [31:0] rdata;
		ltfs_line_t out;
	} ltfs_regs_t;

endpackage : ltfs_pkg

// ---- ltfs_seq_assertions.sv ----
// Watches only the sequencer's ports; keeps shadow copies of written setup
module ltfs_seq_assertions (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire ltfs_pkg::ltfs_line_t line_out
);
	logic [31:0] per_q; // Shadow line period
	logic [31:0] exp_q; // Shadow exposure
	logic [15:0] hgt_q; // Shadow height
	logic grab_q; // Shadow grab bit
	logic [31:0] since_q; // Cycles since the last real line
	logic [31:0] lim; // Shortest legal line spacing
	logic real_ln; // Line carrying sensor data
	assign lim = (per_q > exp_q) ? per_q : exp_q;
	assign real_ln = line_out.line_strobe & ~line_out.zero_fill;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////
	// Shadow setup; a control write restarts spacing, since grab may rearm
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			per_q <= ltfs_pkg::RST_LINE_PERIOD;
			exp_q <= ltfs_pkg::RST_EXPOSURE;
			hgt_q <= ltfs_pkg::RST_HEIGHT;
			grab_q <= 1'b0;
			since_q <= 32'hffff_ffff;
		end else begin
			if (reg_wr && reg_addr == ltfs_pkg::ADDR_LINE_PERIOD) per_q <= reg_wdata;
			if (reg_wr && reg_addr == ltfs_pkg::ADDR_EXPOSURE) exp_q <= reg_wdata;
			if (reg_wr && reg_addr == ltfs_pkg::ADDR_HEIGHT)
				hgt_q <= (reg_wdata[15:0] == 16'h0) ? 16'h1 : reg_wdata[15:0];
			if (reg_wr && reg_addr == ltfs_pkg::ADDR_CTRL) begin
				grab_q <= reg_wdata[0];
				since_q <= 32'hffff_ffff;
			end else if (real_ln) since_q <= 32'h1;
			else if (since_q != 32'hffff_ffff) since_q <= since_q + 32'h1;
		end
	end
	property p_fstart;
		line_out.frame_start |-> line_out.line_strobe && line_out.line_index == 16'h0;
	endproperty
	a_fstart: assert property (p_fstart) else $error("frame start not on line 0");
	property p_fend;
		line_out.frame_end |-> line_out.line_strobe && line_out.line_index == hgt_q - 16'h1;
	endproperty
	a_fend: assert property (p_fend) else $error("frame end off last line");
	property p_space;
		real_ln |-> since_q >= lim;
	endproperty
	a_space: assert property (p_space) else $error("lines too close");
	property p_zf;
		line_out.zero_fill |-> line_out.line_strobe && line_out.line_index != 16'h0;
	endproperty
	a_zf: assert property (p_zf) else $error("bad padding line");
	property p_grab;
		real_ln |-> $past(grab_q);
	endproperty
	a_grab: assert property (p_grab) else $error("line without grab");
	property p_height;
		reg_rd && reg_addr == ltfs_pkg::ADDR_HEIGHT |=> reg_rdata == {16'h0, hgt_q};
	endproperty
	a_height: assert property (p_height) else $error("height readback");
	property p_fper;
		reg_rd && reg_addr == ltfs_pkg::ADDR_FRAME_PERIOD |=> reg_rdata == lim * hgt_q;
	endproperty
	a_fper: assert property (p_fper) else $error("frame period readback");
	property p_rd0;
		reg_rdata != 32'h0 |-> $past(reg_rd);
	endproperty
	a_rd0: assert property (p_rd0) else $error("read data without read");
endmodule : ltfs_seq_assertions

bind ltfs_seq ltfs_seq_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .line_out(line_out));

// ---- ltfs_far_end.sv ----
// Trigger source and frame buffer stand-in
module ltfs_far_end (
	input wire logic sys_clk,
	input wire logic go,
	input wire ltfs_pkg::ltfs_line_t line_out,
	output logic ext_lvl,
	output logic [15:0] n_line,
	output logic [15:0] n_zero,
	output logic [15:0] n_frame
);
	logic [3:0] hold_r = 4'h0; // Pulse cycles left
	initial begin
		n_line = 16'h0;
		n_zero = 16'h0;
		n_frame = 16'h0;
	end
	// Pulse held well past the debounce span so it counts as real
	assign ext_lvl = (hold_r != 4'h0);
	////////////////////////////////////////////////////////////////////
	// Buffer side counts data lines, padding lines and frames
	always @(posedge sys_clk) begin
		if (go) hold_r <= 4'ha;
		else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
		if (line_out.line_strobe & ~line_out.zero_fill) n_line <= n_line + 16'h1;
		if (line_out.zero_fill) n_zero <= n_zero + 16'h1;
		if (line_out.frame_start) n_frame <= n_frame + 16'h1;
	end
endmodule : ltfs_far_end

// ---- testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic frame_trig_in = 1'b0;
	logic tsmod_event = 1'b0;
	logic go = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] v;
	logic ext;
	logic [15:0] nl, nz, nf, bl, bz, bf;
	ltfs_pkg::ltfs_line_t line_out;
	int err_total = 0;
	int n_tests = 0;
	always #25 sys_clk = ~sys_clk;
	// Pause shortened so padding shows within a few hundred cycles
	ltfs_seq #(.PAUSE_CYCLES(32'h0000_0064)) dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_line_sync_input(ext), .frame_trig_in(frame_trig_in),
		.tsmod_event(tsmod_event), .line_out(line_out));
	ltfs_far_end u_far (.sys_clk(sys_clk), .go(go), .line_out(line_out),
		.ext_lvl(ext), .n_line(nl), .n_zero(nz), .n_frame(nf));
	////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask : rd
	// Let lines already in flight land before taking the baseline
	task snap;
		repeat (4) @(posedge sys_clk);
		bl = nl;
		bz = nz;
		bf = nf;
	endtask : snap
	task pulse;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (40) @(posedge sys_clk);
	endtask : pulse
	////////////////////////////////////////////////////////////////////
	// Reset values, unmapped read, height 0 kept as 1, derived period
	task t_regs;
		logic [7:0] a[7] = '{8'h0c, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c, 8'h24};
		logic [31:0] e[7] = '{32'ha, 32'h3e8, 32'h64, 32'h1, 32'h4, 32'h2710, 32'h0};
		for (int i = 0; i < 7; i++) begin
			rd(a[i], v);
			check(v, e[i]);
		end
		wr(ltfs_pkg::ADDR_HEIGHT, 32'h0);
		rd(ltfs_pkg::ADDR_HEIGHT, v);
		check(v, 32'h1);
		wr(ltfs_pkg::ADDR_LINE_PERIOD, 32'h8);
		wr(ltfs_pkg::ADDR_EXPOSURE, 32'hc);
		wr(ltfs_pkg::ADDR_HEIGHT, 32'h4);
		rd(ltfs_pkg::ADDR_FRAME_PERIOD, v);
		check(v, 32'h30);
	endtask : t_regs
	// No grab: an external pulse makes nothing; then free-run
	task t_free;
		snap();
		pulse();
		check({16'h0, nl}, {16'h0, bl});
		wr(ltfs_pkg::ADDR_CTRL, 32'h1);
		repeat (116) @(posedge sys_clk);
		check(32'(nf - bf >= 16'h2), 32'h1);
		rd(ltfs_pkg::ADDR_STATUS, v);
		check({31'h0, v[2]}, 32'h0);
		wr(ltfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_free
	// Per-line external triggers, stop mid-frame, then a fresh frame
	task t_line;
		snap();
		wr(ltfs_pkg::ADDR_CTRL, 32'h7);
		rd(ltfs_pkg::ADDR_STATUS, v);
		check({16'h0, v[31:16]}, 32'h0);
		pulse();
		pulse();
		repeat (150) @(posedge sys_clk);
		check({16'h0, nl - bl}, 32'h2);
		check({16'h0, nz - bz}, 32'h2);
		pulse();
		check({16'h0, line_out.line_index}, 32'h0);
		check({16'h0, line_out.frame_index}, 32'h1);
		check({16'h0, nf - bf}, 32'h2);
		repeat (150) @(posedge sys_clk);
		wr(ltfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_line
	// Three host commands back to back: one runs, one waits, one lost
	task t_cmd;
		snap();
		wr(ltfs_pkg::ADDR_CTRL, 32'hb);
		@(posedge sys_clk);
		reg_addr <= ltfs_pkg::ADDR_CMD;
		reg_wr <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reg_wr <= 1'b0;
		repeat (40) @(posedge sys_clk);
		rd(ltfs_pkg::ADDR_STATUS, v);
		check({31'h0, v[2]}, 32'h1);
		check({16'h0, nl - bl}, 32'h2);
		repeat (150) @(posedge sys_clk);
		wr(ltfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_cmd
	// Falling edge, then either edge with one pending, then timestamp pulses
	task t_src;
		snap();
		wr(ltfs_pkg::ADDR_CTRL, 32'h87);
		pulse();
		check({16'h0, nl - bl}, 32'h1);
		wr(ltfs_pkg::ADDR_CTRL, 32'h107);
		snap();
		pulse();
		check({16'h0, nl - bl}, 32'h2);
		wr(ltfs_pkg::ADDR_CTRL, 32'hf);
		snap();
		repeat (2) begin
			@(posedge sys_clk);
			tsmod_event <= 1'b1;
			@(posedge sys_clk);
			tsmod_event <= 1'b0;
			repeat (20) @(posedge sys_clk);
		end
		check({16'h0, nl - bl}, 32'h2);
		wr(ltfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_src
	// Frame-level types on timer lines; padding counts toward a frame
	task t_frm(input logic [31:0] c, input logic [31:0] fr, input int hold,
		input logic [31:0] n);
		snap();
		wr(ltfs_pkg::ADDR_FRAMES, fr);
		wr(ltfs_pkg::ADDR_CTRL, c);
		@(posedge sys_clk);
		frame_trig_in <= 1'b1;
		repeat (hold) @(posedge sys_clk);
		frame_trig_in <= 1'b0;
		repeat (250) @(posedge sys_clk);
		check({16'h0, nl + nz - bl - bz}, n);
		wr(ltfs_pkg::ADDR_CTRL, 32'h0);
	endtask : t_frm
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_free();
		t_line();
		t_cmd();
		t_src();
		t_frm(32'h13, 32'h1, 5, 32'h4);
		t_frm(32'h23, 32'h2, 5, 32'h8);
		t_frm(32'h33, 32'h1, 30, 32'h4);
		t_frm(32'h43, 32'h1, 5, 32'h4);
		report_and_stop();
	end
	// Watchdog: the whole run needs well under 5000 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		report_and_stop();
	end
endmodule : testbench
